//--- hdl/boot_lock_pkg.sv
package boot_lock_pkg;
    // system control register location (module/index inside accumulator-pointer module)
    localparam logic [3:0] sc_module         = 4'h8;
    localparam logic [3:0] sc_index          = 4'h8;
    localparam int         sc_width          = 8;
    // system control field positions
    localparam int         pwl_bit           = 1;
    localparam int         tap_bit           = 7;
    // reset value with the lock set
    localparam logic [7:0] sc_reset          = 8'h82;
    // key size
    localparam int         key_words         = 16;
    localparam int         key_width         = 16;
    // execution start addresses
    localparam logic [15:0] app_start        = 16'h0000;
    localparam logic [15:0] urom_start       = 16'h8000;
    localparam logic [15:0] urom_words       = 16'h0800;
    // host command codes on the debug port shift register
    localparam logic [3:0] cmd_none          = 4'h0;
    localparam logic [3:0] cmd_spe_set       = 4'h1;
    localparam logic [3:0] cmd_spe_clr       = 4'h2;
    localparam logic [3:0] cmd_key_word      = 4'h3;
    localparam logic [3:0] cmd_sysprog       = 4'h4;
    // bootloader operations
    typedef enum logic [2:0] {
        op_load, op_dump, op_crc, op_verify, op_erase
    } boot_op_type;
endpackage

//--- hdl/key_compare_if.sv
`timescale 1ns/100ps
interface key_compare_if;
    logic        start;      // begin a new key sequence
    logic        word_valid; // one supplied word present
    logic [15:0] word;       // supplied key word
    logic [15:0] stored;     // stored key word at current index
    logic [3:0]  index;      // index of the next expected word
    logic        done;       // pulse: sequence finished
    logic        match;      // all words matched
    modport ctrl (output start, word_valid, word, stored, input index, done, match);
    modport cmp  (input start, word_valid, word, stored, output index, done, match);
endinterface

//--- hdl/key_compare.sv
`timescale 1ns/100ps
// word-by-word comparison of a supplied key against the stored one
module key_compare (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       ce,
    key_compare_if.cmp      kc
);
    typedef struct packed {
        logic [3:0] idx;  // next word index
        logic       ok;   // no mismatch yet
        logic       done; // sequence finished pulse
        logic       hit;  // last result
    } cmp_state_type;
    cmp_state_type s_r, s_nxt;

    // any mismatch poisons the whole sequence, not just that word
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (kc.start) begin
            s_nxt.idx = 4'h0;
            s_nxt.ok = 1'b1;
        end else if (kc.word_valid) begin
            s_nxt.ok = s_r.ok & (kc.word == kc.stored);
            s_nxt.idx = s_r.idx + 4'h1;
            if (s_r.idx == 4'(boot_lock_pkg::key_words - 1)) begin
                s_nxt.done = 1'b1;
                s_nxt.hit = s_r.ok & (kc.word == kc.stored);
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '{idx: 4'h0, ok: 1'b1, done: 1'b0, hit: 1'b0};
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign kc.index = s_r.idx;
    assign kc.done  = s_r.done;
    assign kc.match = s_r.hit;
endmodule

//--- hdl/boot_mode_password_lock.sv
`timescale 1ns/100ps
module boot_mode_password_lock (
    input  wire logic        clk,           // core clock
    input  wire logic        rstn,          // power-on reset
    input  wire logic        ce,            // clock enable
    input  wire logic        core_reset_n,  // core held in reset while low
    // debug port pins (outside domain)
    input  wire logic        tck,           // host shift clock
    input  wire logic        tms,           // port active / capture
    input  wire logic        tdi,           // serial data in
    output logic             tdo,           // serial status out
    // core register access (module/index/bit)
    input  wire logic        reg_wr,        // whole-register write
    input  wire logic        reg_bit_wr,    // single-bit write
    input  wire logic [3:0]  reg_module,    // module specifier
    input  wire logic [3:0]  reg_index,     // register index
    input  wire logic [2:0]  reg_bit,       // bit select
    input  wire logic [7:0]  reg_wdata,     // write data
    output logic [7:0]       reg_rdata,     // read data
    // stored key read and erase notice
    output logic [3:0]       key_addr,      // key word index
    input  wire logic [15:0] key_data,      // stored key word
    input  wire logic        mass_erase_done, // erase finished pulse
    output logic             key_force_ones,  // rewrite key as all ones
    // utility requests
    input  wire logic        util_req,      // debug/program request
    input  wire logic [2:0]  util_op,       // boot_op_type
    input  wire logic        util_from_app, // requested by application
    output logic             util_grant,    // request accepted
    output logic             util_refused,  // request refused
    // execution start
    output logic [15:0]      start_addr,    // first fetch address
    output logic             boot_sel,      // rom chooses bootloader
    output logic             spe_flag,      // programming enable
    output logic             locked         // lock bit state
);
    typedef struct packed {
        logic [2:0]  tck_s;   // tck sync + edge history
        logic [1:0]  tms_s;   // tms sync
        logic [1:0]  tdi_s;   // tdi sync
        logic [19:0] shift;   // host shift register
        logic [4:0]  cnt;     // bits shifted
        logic        sysprog; // system programming instruction loaded
        logic        programming_enable_flag;     // programming enable
        logic [7:0]  sc;      // system control register
        logic        grant;   // grant pulse
        logic        refuse;  // refuse pulse
        logic        erase;   // force-ones pulse
        logic [15:0] start;   // start address
        logic        boot;    // bootloader selected
        logic        tdo;     // output bit
        logic        kstart;  // start key sequence
        logic        kvalid;  // key word valid
        logic [15:0] kword;   // key word
        logic        crst_d;  // core reset last cycle
    } top_state_type;
    top_state_type s_r, s_nxt;

    key_compare_if kc ();
    key_compare u_cmp (
        .clk  (clk),
        .rstn (rstn),
        .ce   (ce),
        .kc   (kc)
    );
    assign kc.start      = s_r.kstart;
    assign kc.word_valid = s_r.kvalid;
    assign kc.word       = s_r.kword;
    assign kc.stored     = key_data;
    assign key_addr      = kc.index;

    logic       tck_rise;  // rising edge of synchronised tck
    logic       sc_hit;    // access aimed at system control
    logic [3:0] cmd;       // command in a completed frame
    logic       util_ok;   // utilities available

    // tck_s[0] is only read by tck_s[1]; edges from stages 1 and 2
    assign tck_rise = s_r.tck_s[1] & ~s_r.tck_s[2];
    assign sc_hit   = (reg_module == boot_lock_pkg::sc_module)
                   && (reg_index == boot_lock_pkg::sc_index);
    assign cmd      = s_r.shift[19:16];
    assign util_ok  = ~s_r.sc[boot_lock_pkg::pwl_bit];

    always_comb begin
        s_nxt = s_r;
        s_nxt.grant  = 1'b0;
        s_nxt.refuse = 1'b0;
        s_nxt.erase  = 1'b0;
        s_nxt.kstart = 1'b0;
        s_nxt.kvalid = 1'b0;
        s_nxt.crst_d = core_reset_n;
        // synchronisers for the port pins
        s_nxt.tck_s = {s_r.tck_s[1:0], tck};
        s_nxt.tms_s = {s_r.tms_s[0], tms};
        s_nxt.tdi_s = {s_r.tdi_s[0], tdi};
        // tap bit mirrors port activity
        s_nxt.sc[boot_lock_pkg::tap_bit] = s_r.tms_s[1];
        // shift host frames; tms low abandons a frame
        if (!s_r.tms_s[1]) begin
            s_nxt.cnt = 5'h0;
        end else if (tck_rise) begin
            s_nxt.shift = {s_r.shift[18:0], s_r.tdi_s[1]};
            s_nxt.tdo   = s_r.sc[boot_lock_pkg::pwl_bit];
            s_nxt.cnt   = s_r.cnt + 5'h1;
        end
        // a full 20-bit frame: 4-bit command, 16-bit data
        if (s_r.cnt == 5'd20) begin
            s_nxt.cnt = 5'h0;
            case (cmd)
                boot_lock_pkg::cmd_sysprog: s_nxt.sysprog = 1'b1;
                boot_lock_pkg::cmd_spe_set: begin
                    // flag only accepted in reset after sysprog
                    if (!core_reset_n && s_r.sysprog) begin
                        s_nxt.programming_enable_flag = 1'b1;
                    end
                end
                boot_lock_pkg::cmd_spe_clr: s_nxt.programming_enable_flag = 1'b0;
                boot_lock_pkg::cmd_key_word: begin
                    if (kc.index == 4'h0) begin
                        s_nxt.kstart = 1'b1;
                    end
                    s_nxt.kvalid = 1'b1;
                    s_nxt.kword  = s_r.shift[15:0];
                end
                default: s_nxt.sysprog = s_r.sysprog;
            endcase
        end
        // key sequence start one cycle ahead of first word
        if (s_r.kstart) begin
            s_nxt.kvalid = 1'b1;
        end
        // full match unlocks; mismatch leaves the bit set
        if (kc.done && kc.match) begin
            s_nxt.sc[boot_lock_pkg::pwl_bit] = 1'b0;
        end
        // software write, whole register or single bit
        if (reg_wr && sc_hit) begin
            s_nxt.sc[boot_lock_pkg::pwl_bit] = reg_wdata[boot_lock_pkg::pwl_bit];
        end else if (reg_bit_wr && sc_hit && reg_bit == 3'(boot_lock_pkg::pwl_bit)) begin
            s_nxt.sc[boot_lock_pkg::pwl_bit] = reg_wdata[0];
        end
        // bootloader or application clears the flag by register write
        if (reg_bit_wr && reg_module == boot_lock_pkg::sc_module
            && reg_index == 4'h9 && reg_wdata[0] == 1'b0) begin
            s_nxt.programming_enable_flag = 1'b0;
        end
        // erase rewrites the key as all ones
        if (mass_erase_done) begin
            s_nxt.erase = 1'b1;
        end
        // utility request gate; ops above erase refused, every other op granted only when unlocked
        if (util_req) begin
            if (util_op > 3'(boot_lock_pkg::op_erase)) begin
                s_nxt.refuse = 1'b1;
            end else if (util_ok) begin
                s_nxt.grant = 1'b1;
            end else begin
                s_nxt.refuse = 1'b1;
            end
        end
        // on reset release the rom picks its target
        if (core_reset_n && !s_r.crst_d) begin
            s_nxt.start = boot_lock_pkg::urom_start;
            s_nxt.boot  = s_r.programming_enable_flag;
        end
    end

    // single register for all state; lock set by power-on reset or by a software write
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
            s_r.sc <= boot_lock_pkg::sc_reset;
            s_r.start <= boot_lock_pkg::urom_start;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign tdo            = s_r.tdo;
    assign reg_rdata      = sc_hit ? s_r.sc : 8'h00;
    assign key_force_ones = s_r.erase;
    assign util_grant     = s_r.grant;
    assign util_refused   = s_r.refuse;
    assign start_addr     = s_r.start;
    assign boot_sel       = s_r.boot;
    assign spe_flag       = s_r.programming_enable_flag;
    assign locked         = s_r.sc[boot_lock_pkg::pwl_bit];
endmodule

//--- sim/boot_lock_props.sv
`timescale 1ns/100ps
// port-level checks of lock, grants, erase notice and boot choice
module boot_lock_props (
    input logic        clk,
    input logic        rstn,
    input logic        core_reset_n,
    input logic        util_req,
    input logic [2:0]  util_op,
    input logic        util_grant,
    input logic        util_refused,
    input logic        mass_erase_done,
    input logic        key_force_ones,
    input logic [3:0]  reg_module,
    input logic [3:0]  reg_index,
    input logic [7:0]  reg_rdata,
    input logic [15:0] start_addr,
    input logic        boot_sel,
    input logic        spe_flag,
    input logic        locked
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // steps of a utility request: asked, then a one-cycle answer
    sequence s_ask_locked; util_req && locked; endsequence
    sequence s_ask_open; util_req && !locked && util_op <= 3'h4; endsequence
    sequence s_no; util_refused && !util_grant ##1 !util_refused; endsequence
    // the control register is the only readable place
    logic sc_sel;
    assign sc_sel = reg_module == 4'h8 && reg_index == 4'h8;
    AST_LOCKED_REFUSE: assert property (s_ask_locked |=> s_no)
        else $error("request served while locked");
    AST_OPEN_GRANT: assert property (s_ask_open |=> util_grant && !util_refused)
        else $error("request refused while open");
    AST_BAD_OP: assert property (util_req && util_op > 3'h4 |=> util_refused)
        else $error("unknown operation served");
    AST_GRANT_CAUSE: assert property (util_grant |-> $past(util_req) && !$past(locked))
        else $error("grant without open request");
    AST_ERASE: assert property (mass_erase_done |=> key_force_ones)
        else $error("erase did not force key ones");
    AST_FORCE_CAUSE: assert property (key_force_ones |-> $past(mass_erase_done))
        else $error("key forced without erase");
    AST_SC_BIT: assert property (sc_sel |-> reg_rdata[1] == locked)
        else $error("lock bit read wrong");
    AST_UNMAPPED: assert property (!sc_sel |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_ROM_START: assert property (start_addr == 16'h8000)
        else $error("start address not rom");
    AST_BOOT_CHOICE: assert property ($rose(core_reset_n) |=> boot_sel == $past(spe_flag))
        else $error("boot choice differs from flag");
    AST_SPE_IN_RESET: assert property ($rose(spe_flag) |-> !$past(core_reset_n))
        else $error("flag set outside core reset");
endmodule
bind boot_mode_password_lock boot_lock_props boot_lock_props_inst (
    .clk(clk), .rstn(rstn), .core_reset_n(core_reset_n), .util_req(util_req),
    .util_op(util_op), .util_grant(util_grant), .util_refused(util_refused),
    .mass_erase_done(mass_erase_done), .key_force_ones(key_force_ones),
    .reg_module(reg_module), .reg_index(reg_index), .reg_rdata(reg_rdata),
    .start_addr(start_addr), .boot_sel(boot_sel), .spe_flag(spe_flag), .locked(locked));

//--- sim/jtag_host_model.sv
`timescale 1ns/100ps
// debug host: 20-bit frames, shift clock stands still between frames
module jtag_host_model (
    output logic tck,
    output logic tms,
    output logic tdi
);
    initial begin
        tck = 1'b0;
        tms = 1'b0;
        tdi = 1'b1;
    end
    // command then data, most significant bit first, 160 ns per bit
    task automatic send(input logic [3:0] cmd, input logic [15:0] data);
        logic [19:0] f;
        f = {cmd, data};
        for (int i = 19; i >= 0; i--) begin
            tms = 1'b1;
            tdi = f[i];
            #80 tck = 1'b1;
            #80 tck = 1'b0;
        end
        tms = 1'b0;
        // released data line shows the inverse, never a stale bit
        tdi = ~f[0];
        #400;
    endtask
    // programming instruction first, then raise the enable flag
    task automatic enter_boot();
        send(boot_lock_pkg::cmd_sysprog, 16'h0000);
        send(boot_lock_pkg::cmd_spe_set, 16'h0001);
    endtask
endmodule

//--- sim/boot_mode_password_lock_bench.sv
`timescale 1ns/100ps
// drives lock, key frames, utility requests and boot entry
module boot_mode_password_lock_bench;
    logic        clk, rstn, core_reset_n, tck, tms, tdi, tdo, reg_wr, reg_bit_wr;
    logic [3:0]  reg_module, reg_index, key_addr;
    logic [2:0]  reg_bit, util_op;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [15:0] key_data, start_addr;
    logic        mass_erase_done, key_force_ones, util_req, util_from_app;
    logic        util_grant, util_refused, boot_sel, spe_flag, locked;
    int          n_fail = 0;
    int          samples_checked = 0;
    // stored key: word i is a500h xor i
    assign key_data = 16'ha500 ^ {12'h000, key_addr};
    boot_mode_password_lock boot_mode_password_lock_inst (.clk(clk), .rstn(rstn),
        .ce(1'b1), .core_reset_n(core_reset_n), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .reg_wr(reg_wr), .reg_bit_wr(reg_bit_wr), .reg_module(reg_module),
        .reg_index(reg_index), .reg_bit(reg_bit), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .key_addr(key_addr), .key_data(key_data),
        .mass_erase_done(mass_erase_done), .key_force_ones(key_force_ones),
        .util_req(util_req), .util_op(util_op), .util_from_app(util_from_app),
        .util_grant(util_grant), .util_refused(util_refused), .start_addr(start_addr),
        .boot_sel(boot_sel), .spe_flag(spe_flag), .locked(locked));
    jtag_host_model jtag_host_model_inst (.tck(tck), .tms(tms), .tdi(tdi));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one-cycle register write, whole or single bit; data 00h/ffh fits either
    task automatic wr(input logic bw, input logic [3:0] x, input logic [2:0] b,
                      input logic [7:0] d);
        reg_bit_wr = bw;
        reg_wr = !bw;
        reg_module = 4'h8;
        reg_index = x;
        reg_bit = b;
        reg_wdata = d;
        cyc(1);
        reg_wr = 1'b0;
        reg_bit_wr = 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [3:0] m, input logic [7:0] e);
        reg_module = m;
        reg_index = 4'h8;
        cyc(1);
        chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, e});
    endtask
    // answer is a pulse in the cycle after the request
    task automatic req(input logic [2:0] op, input logic ok);
        util_req = 1'b1;
        util_op = op;
        cyc(1);
        util_req = 1'b0;
        chk("util_grant", {15'h0, util_grant}, {15'h0, ok});
        chk("util_refused", {15'h0, util_refused}, {15'h0, !ok});
        cyc(1);
    endtask
    // sixteen key frames; word number bad is spoiled
    task automatic send_key(input int bad);
        for (int i = 0; i < 16; i++)
            jtag_host_model_inst.send(4'h3, 16'ha500 ^ i[15:0] ^ (i == bad ? 16'h40 : 16'h0));
        cyc(10);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        {rstn, reg_wr, reg_bit_wr, reg_module, reg_index, reg_bit, reg_wdata} = '0;
        {mass_erase_done, util_req, util_op, util_from_app} = '0;
        core_reset_n = 1'b1;
        repeat (12) @(posedge clk);
        #1 rstn = 1'b1;
        cyc(1);
        chk("locked", {15'h0, locked}, 16'h1);
        // tap bit follows the idle port (tms low) one cycle after reset, so it reads 0
        rd(4'h8, 8'h02);
        rd(4'h3, 8'h00);
        chk("start_addr", start_addr, 16'h8000);
        for (int op = 0; op < 5; op++) req(op[2:0], 1'b0);
        // flag set without the programming instruction is ignored
        core_reset_n = 1'b0;
        jtag_host_model_inst.send(4'h1, 16'h0001);
        cyc(10);
        chk("spe_flag", {15'h0, spe_flag}, 16'h0);
        core_reset_n = 1'b1;
        cyc(2);
        send_key(5);
        chk("locked", {15'h0, locked}, 16'h1);
        chk("tdo", {15'h0, tdo}, 16'h1);
        send_key(16);
        chk("locked", {15'h0, locked}, 16'h0);
        for (int op = 0; op < 6; op++) begin
            util_from_app = op[0];
            req(op[2:0], op < 5);
        end
        wr(1'b1, 4'h8, 3'h1, 8'hff);
        rd(4'h8, 8'h02);
        req(3'h0, 1'b0);
        wr(1'b0, 4'h8, 3'h0, 8'h80);
        chk("locked", {15'h0, locked}, 16'h0);
        mass_erase_done = 1'b1;
        cyc(1);
        mass_erase_done = 1'b0;
        chk("key_force_ones", {15'h0, key_force_ones}, 16'h1);
        core_reset_n = 1'b0;
        cyc(2);
        jtag_host_model_inst.enter_boot();
        cyc(10);
        chk("spe_flag", {15'h0, spe_flag}, 16'h1);
        chk("tdo", {15'h0, tdo}, 16'h0);
        core_reset_n = 1'b1;
        cyc(3);
        chk("boot_sel", {15'h0, boot_sel}, 16'h1);
        wr(1'b1, 4'h9, 3'h0, 8'h00);
        chk("spe_flag", {15'h0, spe_flag}, 16'h0);
        core_reset_n = 1'b0;
        cyc(3);
        core_reset_n = 1'b1;
        cyc(3);
        chk("boot_sel", {15'h0, boot_sel}, 16'h0);
        report_and_stop();
    end
    // cut a hang short well past the expected run
    initial begin
        #1000000;
        n_fail++;
        report_and_stop();
    end
endmodule
